// ===== include/tsec_pkg.sv
// Shared constants, register map and helpers of the two-stage event controller
package tsec_pkg;
	// Data and address widths of the register slave
	localparam int DATA_W = 32;
	localparam int ADDR_W = 5;
	localparam int NSRC = 32;
	localparam int NLEV = 16;
	localparam int LEV_W = 4;

	// Event levels, lowest number has highest priority
	localparam logic [3:0] LEV_EMU = 4'h0;
	localparam logic [3:0] LEV_RST = 4'h1;
	localparam logic [3:0] LEV_NMI = 4'h2;
	localparam logic [3:0] LEV_EXC = 4'h3;
	localparam logic [3:0] LEV_GP_LO = 4'h7;
	localparam logic [3:0] LEV_GP13 = 4'hD;
	localparam logic [15:0] GP_LEVELS = 16'hFF80;
	localparam logic [15:0] NONMASK = 16'h000F;

	// Peripheral identifiers with a fixed default level
	localparam int SRC_MDMA0 = 29;
	localparam int SRC_MDMA1 = 30;
	localparam int SRC_WDOG_PORT = 31;
	localparam int GP_COUNT = 9;

	// Byte addresses of the registers
	localparam logic [4:0] OFF_CORE_LATCH = 5'h00;
	localparam logic [4:0] OFF_CORE_MASK = 5'h04;
	localparam logic [4:0] OFF_CORE_ACTIVE = 5'h08;
	localparam logic [4:0] OFF_PIRQ_MASK = 5'h0C;
	localparam logic [4:0] OFF_PIRQ_STATUS = 5'h10;
	localparam logic [4:0] OFF_PIRQ_WAKE = 5'h14;
	localparam logic [4:0] OFF_CTRL_STATUS = 5'h18;
	localparam logic [4:0] OFF_SW_RAISE = 5'h1C;

	// Status register field positions
	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_SUP_BIT = 1;
	localparam int CTRL_EMU_BIT = 2;
	localparam int CTRL_RST_BIT = 3;

	// Reset values
	localparam logic [15:0] CORE_MASK_RST = 16'h0000;
	localparam logic [31:0] PIRQ_MASK_RST = 32'h00000000;
	localparam logic [31:0] PIRQ_WAKE_RST = 32'h00000000;
	localparam logic GIE_RST = 1'b0;

	// Default level of each peripheral source
	function automatic logic [3:0] src_level(input int id);
		logic [3:0] lv;
		if (id >= SRC_MDMA0) begin
			lv = LEV_GP13;
		end else begin
			lv = 4'(int'(LEV_GP_LO) + (id % GP_COUNT));
		end
		return lv;
	endfunction

	// Sources routed onto one level
	function automatic logic [31:0] level_srcs(input int lv);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = 0; i < NSRC; i++) begin
			m[i] = (int'(src_level(i)) == lv);
		end
		return m;
	endfunction

	// Index of lowest set bit, top bit flags any set
	function automatic logic [4:0] lowest(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NLEV - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// Byte enables widened to a bit mask
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction
endpackage

// ===== hdl/tsec_sys_stage.sv
// System stage: peripheral request sync, mask, status, wake and routing
`timescale 1ns/1ps
module tsec_sys_stage (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [31:0] periphReq,
	input wire logic maskWr,
	input wire logic wakeWr,
	input wire logic [31:0] wrData,
	input wire logic [31:0] wrMask,
	input wire logic coreIdle,
	input wire logic [15:0] coreActive,
	output logic [15:0] gpReq,
	output logic [31:0] irqStatus,
	output logic [31:0] irqMask,
	output logic [31:0] wakeEn,
	output logic wakeUp
);
	typedef struct packed {
		logic [31:0] syn1;
		logic [31:0] syn2;
		logic [31:0] mask;
		logic [31:0] wake;
		logic [15:0] actPrev;
		logic [15:0] gp;
		logic wakeUp;
	} tsec_sys_state_t;

	tsec_sys_state_t s_q;
	tsec_sys_state_t s_d;
	logic [15:0] levelHit;

	// route and merge
	// Masked requests of one level are ORed into its input
	for (genvar l = 0; l < tsec_pkg::NLEV; l++) begin : gLevel
		localparam logic [31:0] SRCS = tsec_pkg::level_srcs(l);
		assign levelHit[l] = |(s_q.syn2 & s_q.mask & SRCS);
	end

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.syn1 = periphReq;
		s_d.syn2 = s_q.syn1;
		if (maskWr) begin
			s_d.mask = (s_q.mask & ~wrMask) | (wrData & wrMask);
		end
		if (wakeWr) begin
			s_d.wake = (s_q.wake & ~wrMask) | (wrData & wrMask);
		end
		// acknowledge rearms level
		// A fresh active bit drops the level for one cycle, so a
		// source still high after the ack gives a new rising edge
		s_d.actPrev = coreActive;
		s_d.gp = levelHit & ~(coreActive & ~s_q.actPrev);
		s_d.wakeUp = coreIdle & |(s_q.syn2 & s_q.wake);
	end

	// State registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{mask: tsec_pkg::PIRQ_MASK_RST,
				wake: tsec_pkg::PIRQ_WAKE_RST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign gpReq = s_q.gp;
	assign irqStatus = s_q.syn2;
	assign irqMask = s_q.mask;
	assign wakeEn = s_q.wake;
	assign wakeUp = s_q.wakeUp;
endmodule // tsec_sys_stage

// ===== hdl/tsec_event_ctrl.sv
// Core event stage, register slave and system stage of the event controller
// Function
// - Handle emulation, reset, NMI, exception and interrupt event classes.
// - Nest active events; higher priority events are serviced first.
// - NMI comes from the watchdog or the external NMI pin.
// - Exceptions follow program flow and hold the instruction.
// - Interrupts come from pins, timers, peripherals or a software raise.
// - Each level keeps a return address and a return-from-event path.
// - Peripheral requests pass the system stage onto general levels.
// - Memory DMA streams, watchdog and port map to level 13.
// - The core stage keeps 16-bit latch, mask and active registers.
// - Latch sets on event, clears on accept; writes only where the mask bit is clear.
// - Set mask bit allows service; mask access needs supervisor mode.
// - Global enable and disable instructions gate general levels.
// - Active bit stands while its event is active or nested.
// - System stage has three 32-bit per-source registers.
// - Peripheral mask bit lets its request through.
// - Peripheral status shows each source now asserting.
// - Wake-enabled source wakes an idle core.
// - System stage takes the active bits as acknowledgement.
// - Latch sets on a rising edge, detected over two cycles.
// - Latch clears as active sets; the next edge is queued.
// - Edge to active bit takes at least three cycles.
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tsec_event_ctrl (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [31:0] periphReq,
	input wire logic coreIdle,
	input wire logic superMode,
	input wire logic nmiPin,
	input wire logic emuPin,
	input wire logic resetEvtPin,
	input wire logic wdogNmi,
	input wire logic excReq,
	input wire logic gieSetInstr,
	input wire logic gieClrInstr,
	input wire logic evtAck,
	input wire logic evtRet,
	input wire logic [3:0] evtRetLevel,
	input wire logic [31:0] pcIn,
	output logic evtReq,
	output logic [3:0] evtLevel,
	output logic [31:0] retPc,
	output logic emuMode,
	output logic coreResetOut,
	output logic excHold,
	output logic wakeUp
);
	// Pin bits in the synchroniser
	localparam int PIN_NMI = 0;
	localparam int PIN_EMU = 1;
	localparam int PIN_RST = 2;

	typedef struct packed {
		logic [2:0] syn1;
		logic [2:0] syn2;
		logic [2:0] pinPrev;
		logic [15:0] gpS;
		logic [15:0] gpPrev;
		logic [15:0] latch;
		logic [15:0] mask;
		logic [15:0] active;
		logic gie;
		logic [15:0][31:0] retAddr;
		logic [31:0] retPc;
		logic evtReq;
		logic [3:0] evtLevel;
		logic emuMode;
		logic coreResetOut;
		logic excHold;
		logic waitReq;
		logic [31:0] rdata;
	} tsec_core_state_t;

	tsec_core_state_t s_q;
	tsec_core_state_t s_d;

	// Bus decode signals
	logic busTake;
	logic [31:0] wMask;
	logic pMaskWr;
	logic pWakeWr;
	logic [15:0] gpReq;
	logic [31:0] irqStatus;
	logic [31:0] irqMask;
	logic [31:0] wakeEn;
	logic sysWake;

	// Bus request is taken while waitrequest stands high
	assign busTake = (avs_read | avs_write) & s_q.waitReq;
	assign wMask = tsec_pkg::be_mask(avs_byteenable);

	// system registers written through the slave
	assign pMaskWr = busTake & avs_write &
		(avs_address == tsec_pkg::OFF_PIRQ_MASK);
	assign pWakeWr = busTake & avs_write &
		(avs_address == tsec_pkg::OFF_PIRQ_WAKE);

	// System stage feeds the general levels of the core stage
	tsec_sys_stage uSys (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.periphReq(periphReq),
		.maskWr(pMaskWr),
		.wakeWr(pWakeWr),
		.wrData(avs_writedata),
		.wrMask(wMask),
		.coreIdle(coreIdle),
		.coreActive(s_q.active),
		.gpReq(gpReq),
		.irqStatus(irqStatus),
		.irqMask(irqMask),
		.wakeEn(wakeEn),
		.wakeUp(sysWake)
	);

	// Event processing and register slave
	always_comb begin
		logic nmiLvl;
		logic [2:0] pinEdge;
		logic [15:0] gpEdge;
		logic [15:0] sets;
		logic [15:0] wrOk;
		logic [15:0] enable;
		logic [15:0] cand;
		logic [15:0] allow;
		logic [4:0] top;
		logic [4:0] pick;
		logic [31:0] rd;
		nmiLvl = 1'b0;
		pinEdge = 3'h0;
		gpEdge = 16'h0000;
		sets = 16'h0000;
		wrOk = 16'h0000;
		enable = 16'h0000;
		cand = 16'h0000;
		allow = 16'h0000;
		top = 5'h00;
		pick = 5'h00;
		rd = 32'h00000000;
		s_d = s_q;

		// Pins pass two flops before any logic looks at them
		s_d.syn1 = {resetEvtPin, emuPin, nmiPin};
		s_d.syn2 = s_q.syn1;
		nmiLvl = s_q.syn2[PIN_NMI] | wdogNmi;
		pinEdge = {s_q.syn2[PIN_RST], s_q.syn2[PIN_EMU], nmiLvl} &
			~s_q.pinPrev;
		s_d.pinPrev = {s_q.syn2[PIN_RST], s_q.syn2[PIN_EMU], nmiLvl};

		// three-cycle minimum latency
		// The extra sample stage keeps edge to active at three cycles or more
		s_d.gpS = gpReq & tsec_pkg::GP_LEVELS;
		s_d.gpPrev = s_q.gpS;
		gpEdge = s_q.gpS & ~s_q.gpPrev;

		sets[tsec_pkg::LEV_EMU] = pinEdge[PIN_EMU];
		sets[tsec_pkg::LEV_RST] = pinEdge[PIN_RST];
		sets[tsec_pkg::LEV_NMI] = pinEdge[PIN_NMI];
		sets[tsec_pkg::LEV_EXC] = excReq;
		sets = sets | gpEdge;

		// global enable instructions
		// Disable wins when both arrive together
		if (gieSetInstr) begin
			s_d.gie = 1'b1;
		end
		if (gieClrInstr) begin
			s_d.gie = 1'b0;
		end

		// Register slave: one cycle with waitrequest low per request
		s_d.waitReq = 1'b1;
		if (busTake) begin
			s_d.waitReq = 1'b0;
			if (avs_write) begin
				unique case (avs_address)
					tsec_pkg::OFF_CORE_LATCH: begin
						wrOk = ~s_q.mask & wMask[15:0];
						s_d.latch = (s_q.latch & ~wrOk) |
							(avs_writedata[15:0] & wrOk);
					end
					tsec_pkg::OFF_CORE_MASK: begin
						if (superMode) begin
							s_d.mask = (s_q.mask & ~wMask[15:0]) |
								(avs_writedata[15:0] & wMask[15:0]);
						end
					end
					tsec_pkg::OFF_SW_RAISE: begin
						sets = sets | (avs_writedata[15:0] &
							wMask[15:0] & tsec_pkg::GP_LEVELS);
					end
					default: begin
						// Read-only and unmapped words ignore writes
					end
				endcase
			end else begin
				unique case (avs_address)
					tsec_pkg::OFF_CORE_LATCH: begin
						rd = {16'h0000, s_q.latch};
					end
					tsec_pkg::OFF_CORE_MASK: begin
						if (superMode) begin
							rd = {16'h0000, s_q.mask};
						end
					end
					tsec_pkg::OFF_CORE_ACTIVE: begin
						if (superMode) begin
							rd = {16'h0000, s_q.active};
						end
					end
					tsec_pkg::OFF_PIRQ_MASK: begin
						rd = irqMask;
					end
					tsec_pkg::OFF_PIRQ_STATUS: begin
						rd = irqStatus;
					end
					tsec_pkg::OFF_PIRQ_WAKE: begin
						rd = wakeEn;
					end
					tsec_pkg::OFF_CTRL_STATUS: begin
						rd[tsec_pkg::CTRL_GIE_BIT] = s_q.gie;
						rd[tsec_pkg::CTRL_SUP_BIT] = superMode;
						rd[tsec_pkg::CTRL_EMU_BIT] = s_q.emuMode;
						rd[tsec_pkg::CTRL_RST_BIT] = s_q.coreResetOut;
					end
					default: begin
						// Unmapped and write-only words read zero
						rd = 32'h00000000;
					end
				endcase
			end
			s_d.rdata = rd;
		end

		// return from event
		// Return clears before accept so a same-cycle re-entry stands
		if (evtRet) begin
			s_d.active[evtRetLevel] = 1'b0;
			s_d.retPc = s_q.retAddr[evtRetLevel];
		end

		if (evtAck && s_q.evtReq) begin
			s_d.active[s_q.evtLevel] = 1'b1;
			s_d.latch[s_q.evtLevel] = 1'b0;
			s_d.retAddr[s_q.evtLevel] = pcIn;
		end

		// hardware set wins
		// A new edge in the accept cycle is queued, not lost
		s_d.latch = s_d.latch | sets;

		enable = s_d.mask | tsec_pkg::NONMASK;
		if (!s_d.gie) begin
			enable = enable & ~tsec_pkg::GP_LEVELS;
		end
		cand = s_d.latch & enable;

		// nesting needs higher priority
		// Only levels above the highest active one may preempt
		top = tsec_pkg::lowest(s_d.active);
		allow = top[4] ? 16'((17'h00001 << top[3:0]) - 17'h00001) :
			16'hFFFF;

		pick = tsec_pkg::lowest(cand & allow);
		s_d.evtReq = pick[4];
		s_d.evtLevel = pick[4] ? pick[3:0] : s_q.evtLevel;

		s_d.emuMode = s_d.active[tsec_pkg::LEV_EMU];
		s_d.coreResetOut = s_d.active[tsec_pkg::LEV_RST];
		s_d.excHold = s_d.latch[tsec_pkg::LEV_EXC];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{mask: tsec_pkg::CORE_MASK_RST,
				gie: tsec_pkg::GIE_RST, waitReq: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.waitReq;
	assign evtReq = s_q.evtReq;
	assign evtLevel = s_q.evtLevel;
	assign retPc = s_q.retPc;
	assign emuMode = s_q.emuMode;
	assign coreResetOut = s_q.coreResetOut;
	assign excHold = s_q.excHold;
	assign wakeUp = sysWake;
endmodule // tsec_event_ctrl

// ===== tb/tsec_event_ctrl_assertions.sv
// Checker of bus handshake and event offer timing
`timescale 1ns/1ps
module tsec_event_ctrl_assertions (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic coreIdle,
	input wire logic excReq,
	input wire logic evtAck,
	input wire logic evtReq,
	input wire logic [3:0] evtLevel,
	input wire logic emuMode,
	input wire logic excHold,
	input wire logic wakeUp
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Bus answer one cycle after take, for one cycle only
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("request not answered");
	bus_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	bus_idle_a: assert property (!(avs_read || avs_write) && avs_waitrequest
		|=> avs_waitrequest) else $error("answer without request");
	// Exception seen as held soon after it is raised
	exc_latch_a: assert property (excReq |-> ##[1:2] excHold)
		else $error("exception not latched");
	// After a take only a higher priority level may be offered
	nest_order_a: assert property (evtAck && evtReq |=> !evtReq ||
		(evtLevel < $past(evtLevel))) else $error("nested offer order");
	level_range_a: assert property (evtReq |->
		(evtLevel <= tsec_pkg::LEV_EXC) || (evtLevel >= tsec_pkg::LEV_GP_LO))
		else $error("offered level unused");
	emu_enter_a: assert property (evtAck && evtReq &&
		evtLevel == tsec_pkg::LEV_EMU |-> ##[1:2] emuMode)
		else $error("emulation not entered");
	// A busy core is never woken
	wake_idle_a: assert property (!coreIdle |=> !wakeUp)
		else $error("wake while core busy");
	cover property (evtAck && evtReq && evtLevel == tsec_pkg::LEV_GP13);
	cover property (evtAck && evtReq && evtLevel == tsec_pkg::LEV_NMI);
	cover property (wakeUp);
endmodule // tsec_event_ctrl_assertions

bind tsec_event_ctrl tsec_event_ctrl_assertions tsec_event_ctrl_assertions_inst (
	.ref_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .coreIdle,
	.excReq, .evtAck, .evtReq, .evtLevel, .emuMode, .excHold, .wakeUp);

// ===== tb/tsec_core_model.sv
// Core pipeline stand-in that takes offered events
`timescale 1ns/1ps
module tsec_core_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [3:0] delay,
	input wire logic evtReq,
	input wire logic [3:0] evtLevel,
	output logic evtAck,
	output logic [31:0] pcIn
);
	logic [3:0] waitQ;
	// Return address carries the level so saves can be told apart
	assign pcIn = {28'h0000100, evtLevel};
	// One-cycle ack so a re-evaluated offer is never taken twice
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			evtAck <= 1'b0;
			waitQ <= 4'h0;
		end else if (evtAck || !evtReq || !enable) begin
			evtAck <= 1'b0;
			waitQ <= 4'h0;
		end else if (waitQ >= delay) begin
			evtAck <= 1'b1;
		end else begin
			waitQ <= waitQ + 4'h1;
		end
	end
endmodule // tsec_core_model

// ===== tb/test_tsec_event_ctrl.sv
// Self-checking bench of the two-stage event controller
`timescale 1ns/1ps
module test_tsec_event_ctrl;
	typedef struct packed {
		logic [4:0] addr;
		logic wr;
		logic [31:0] data;
		logic [3:0] be;
		logic [31:0] exp;
	} tsec_row_t;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] periphReq = 32'h00000000;
	logic coreIdle = 1'b0, superMode = 1'b1, nmiPin = 1'b0, emuPin = 1'b0;
	logic resetEvtPin = 1'b0, wdogNmi = 1'b0, excReq = 1'b0;
	logic gieSetInstr = 1'b0, gieClrInstr = 1'b0, evtRet = 1'b0;
	logic [3:0] evtRetLevel = 4'h0;
	logic coreOn = 1'b0;
	logic [3:0] coreDelay = 4'h0;
	logic avs_waitrequest, evtAck, evtReq, emuMode, coreResetOut;
	logic excHold, wakeUp;
	logic [31:0] avs_readdata, pcIn, retPc, rd;
	logic [3:0] evtLevel;
	int n_fail = 0;
	int comparisons = 0;
	int cyc;
	// Register table: address, write, data, byte enables, read-back
	tsec_row_t rows [13] = '{
		'{5'h04, 1'b0, 32'h00000000, 4'hF, 32'h00000000},
		'{5'h0C, 1'b0, 32'h00000000, 4'hF, 32'h00000000},
		'{5'h14, 1'b0, 32'h00000000, 4'hF, 32'h00000000},
		'{5'h08, 1'b0, 32'h00000000, 4'hF, 32'h00000000},
		'{5'h18, 1'b0, 32'h00000000, 4'hF, 32'h00000002},
		'{5'h03, 1'b1, 32'hFFFFFFFF, 4'hF, 32'h00000000},
		'{5'h0C, 1'b1, 32'hFFFFFFFF, 4'hF, 32'hFFFFFFFF},
		'{5'h04, 1'b1, 32'hFFFFE000, 4'hF, 32'h0000E000},
		'{5'h00, 1'b1, 32'h00002100, 4'hF, 32'h00000100},
		'{5'h00, 1'b1, 32'h00000000, 4'hF, 32'h00000000},
		'{5'h14, 1'b1, 32'hFFFFFFFF, 4'h1, 32'h000000FF},
		'{5'h10, 1'b1, 32'hFFFFFFFF, 4'hF, 32'h00000000},
		'{5'h08, 1'b1, 32'h0000FFFF, 4'hF, 32'h00000000}};

	tsec_event_ctrl tsec_event_ctrl_inst (.ref_clk, .rst_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .periphReq, .coreIdle, .superMode, .nmiPin, .emuPin,
		.resetEvtPin, .wdogNmi, .excReq, .gieSetInstr, .gieClrInstr, .evtAck,
		.evtRet, .evtRetLevel, .pcIn, .evtReq, .evtLevel, .retPc, .emuMode,
		.coreResetOut, .excHold, .wakeUp);
	tsec_core_model tsec_core_model_inst (.ref_clk, .rst_n, .enable(coreOn),
		.delay(coreDelay), .evtReq, .evtLevel, .evtAck, .pcIn);

	// Clock of 5 ns period
	always #2.5 ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask

	// One bus cycle; an edge passes first so no signal is driven twice
	task automatic bus(input logic [4:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= b;
		// Only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic ret(input logic [3:0] lv);
		@(posedge ref_clk);
		evtRet <= 1'b1;
		evtRetLevel <= lv;
		@(posedge ref_clk);
		evtRet <= 1'b0;
	endtask

	task automatic end_sim();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			bus(rows[i].addr, rows[i].wr, rows[i].data, rows[i].be, rd);
			if (rows[i].wr) bus(rows[i].addr, 1'b0, 32'h0, 4'hF, rd);
			chk(rd, rows[i].exp);
		end
		$display("register table done");
		superMode <= 1'b0;
		bus(5'h04, 1'b0, 32'h0, 4'hF, rd);
		chk(rd, 32'h00000000);
		superMode <= 1'b1;
		gieSetInstr <= 1'b1;
		@(posedge ref_clk);
		gieSetInstr <= 1'b0;
		$display("supervisor test done");
		// Shared level 13 source held while the core waits
		periphReq[30] <= 1'b1;
		cyc = 0;
		while (evtReq !== 1'b1 && cyc < 40) begin
			@(posedge ref_clk);
			cyc++;
		end
		chk(cyc >= 3, 1'b1);
		chk(evtLevel, tsec_pkg::LEV_GP13);
		bus(5'h10, 1'b0, 32'h0, 4'hF, rd);
		chk(rd, 32'h40000000);
		bus(5'h18, 1'b0, 32'h0, 4'hF, rd);
		chk(rd, 32'h00000003);
		coreOn <= 1'b1;
		// Ack lands one edge later, the active bit one edge after that
		repeat (2) @(posedge ref_clk);
		bus(5'h08, 1'b0, 32'h0, 4'hF, rd);
		chk(rd, 32'h00002000);
		$display("peripheral path done");
		// Exception and watchdog NMI together, nested over level 13
		coreOn <= 1'b0;
		excReq <= 1'b1;
		wdogNmi <= 1'b1;
		@(posedge ref_clk);
		excReq <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(evtLevel, tsec_pkg::LEV_NMI);
		chk(excHold, 1'b1);
		coreDelay <= 4'h3;
		coreOn <= 1'b1;
		repeat (12) @(posedge ref_clk);
		bus(5'h08, 1'b0, 32'h0, 4'hF, rd);
		chk(rd, 32'h00002004);
		ret(tsec_pkg::LEV_NMI);
		repeat (12) @(posedge ref_clk);
		chk(excHold, 1'b0);
		ret(tsec_pkg::LEV_EXC);
		ret(tsec_pkg::LEV_GP13);
		repeat (2) @(posedge ref_clk);
		chk(retPc, 32'h0000100D);
		$display("nesting test done");
		coreIdle <= 1'b1;
		periphReq[0] <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk(wakeUp, 1'b1);
		coreIdle <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(wakeUp, 1'b0);
		emuPin <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk(emuMode, 1'b1);
		$display("wake and emulation done");
		// Reset in mid-run clears outputs and registers
		emuPin <= 1'b0;
		rst_n <= 1'b0;
		@(posedge ref_clk);
		chk(avs_waitrequest, 1'b1);
		chk(emuMode, 1'b0);
		rst_n <= 1'b1;
		bus(5'h0C, 1'b0, 32'h0, 4'hF, rd);
		chk(rd, 32'h00000000);
		// Reset event pin outranks the pending watchdog NMI
		resetEvtPin <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk(coreResetOut, 1'b1);
		$display("reset test done");
		end_sim();
	end
endmodule // test_tsec_event_ctrl
